// ### voice_defines.svh
// register offsets, writable-bit mask, reset values and rate constants for the voice path
`ifndef VOICE_DEFINES_SVH
`define VOICE_DEFINES_SVH
`define OFF_ENABLE 8'h00
`define OFF_SPARE 8'h08
`define OFF_CTRL1 8'h0C
`define OFF_STATUS 8'h1C
`define CTRL1_RESET 32'h0028_2004
`define CTRL1_MASK 32'h007F_33EF
`define GAIN_UNITY 7'h28
`define GAIN_MAX 7'h50
`define PDM_CLK_HZ 1280000
`define CORE_RATE_HZ 320000
`define PDM_DECIM (`PDM_CLK_HZ / `CORE_RATE_HZ)
`define MID_SCALE 13'h0800
`define DC_SHIFT 14
`define LOG_DECIM 6'h28
`endif

// ### voice_pkg.sv
// types shared by the voice input path
package voice_pkg;
	typedef enum logic [1:0] {ENC_ALAW = 2'h0, ENC_ULAW = 2'h1, ENC_CVSD = 2'h2, ENC_BYPASS = 2'h3} encode_t;
	typedef struct packed {
		logic [6:0] gain;
		encode_t encode;
		logic [1:0] rate;
		logic fir_bw;
		logic companding_law_select;
		logic channel_side_select;
		logic [1:0] dc_removal_setting;
		logic polarity;
		logic mic;
	} ctrl_t;
	typedef enum logic [1:0] {ST_OFF = 2'b01, ST_RUN = 2'b10} core_state_t;
	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} voice_word_t;
endpackage

// ### voice_input_datapath.sv
// voice input path: pdm/adc capture, filtering, gain, companding, axi4-lite registers
`timescale 1ns/1ns
`include "voice_defines.svh"
module voice_input_datapath (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic pdm_clk,
	input wire logic pdm_data,
	input wire logic [11:0] adc_data,
	input wire logic adc_valid,
	output voice_pkg::voice_word_t voice_out
);
	logic enable_reg;
	voice_pkg::ctrl_t ctrl_reg;
	voice_pkg::core_state_t state_reg;
	logic aw_full, w_full;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic run;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction

	// control word to and from its register image, reserved bits read as zero
	function automatic logic [31:0] ctrl_pack(input voice_pkg::ctrl_t c);
		return {9'h000, c.gain, 2'h0, c.encode, 2'h0, c.rate, c.fir_bw, c.companding_law_select,
			c.channel_side_select, 1'b0, c.dc_removal_setting, c.polarity, c.mic};
	endfunction

	function automatic voice_pkg::ctrl_t ctrl_unpack(input logic [31:0] w);
		voice_pkg::ctrl_t c;
		c.gain = w[22:16];
		c.encode = voice_pkg::encode_t'(w[13:12]);
		c.rate = w[9:8];
		c.fir_bw = w[7];
		c.companding_law_select = w[6];
		c.channel_side_select = w[5];
		c.dc_removal_setting = w[3:2];
		c.polarity = w[1];
		c.mic = w[0];
		return c;
	endfunction

	function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
		if (v > 32'sh0000_7FFF)
			return 16'sh7FFF;
		else if (v < -32'sh0000_8000)
			return 16'sh8000;
		else
			return v[15:0];
	endfunction

	function automatic logic [16:0] absval(input logic signed [15:0] x);
		return x[15] ? 17'(-$signed({x[15], x})) : {1'b0, x};
	endfunction

	function automatic logic [7:0] ulaw_enc(input logic signed [15:0] x);
		logic [14:0] t;
		logic [12:0] b;
		logic [2:0] seg;
		t = 15'(absval(x) >> 2) + 15'h0021;
		b = (t > 15'h1FFF) ? 13'h1FFF : t[12:0];
		seg = 3'h0;
		for (int i = 0; i < 8; i++)
			if (b[i+5])
				seg = 3'(i);
		return ~{x[15], seg, 4'(b >> (seg + 3'h1))};
	endfunction

	function automatic logic [7:0] alaw_enc(input logic signed [15:0] x);
		logic [13:0] t;
		logic [11:0] m;
		logic [2:0] seg;
		t = 14'(absval(x) >> 3);
		m = (t > 14'h0FFF) ? 12'hFFF : t[11:0];
		seg = 3'h0;
		for (int i = 5; i < 12; i++)
			if (m[i])
				seg = 3'(i - 4);
		return {~x[15], seg, (seg == 3'h0) ? 4'(m >> 1) : 4'(m >> seg)} ^ 8'h55;
	endfunction

	// axi4-lite slave
	assign awready = ce & ~aw_full;
	assign wready = ce & ~w_full;
	assign arready = ce & ~rvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			bvalid <= 1'b0;
			bresp <= 2'h0;
			enable_reg <= 1'b0;
			ctrl_reg <= ctrl_unpack(`CTRL1_RESET);
		end
		else if (ce)
		begin
			if (awvalid && !aw_full)
			begin
				aw_full <= 1'b1;
				aw_addr_reg <= awaddr;
			end
			if (wvalid && !w_full)
			begin
				w_full <= 1'b1;
				w_data_reg <= wdata;
				w_strb_reg <= wstrb;
			end
			if (bvalid && bready)
				bvalid <= 1'b0;
			if (aw_full && w_full && !bvalid)
			begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				bvalid <= 1'b1;
				bresp <= 2'h0;
				if (aw_addr_reg == `OFF_ENABLE)
					enable_reg <= w_strb_reg[0] ? w_data_reg[0] : enable_reg;
				else if (aw_addr_reg == `OFF_CTRL1)
					ctrl_reg <= ctrl_unpack(merge(ctrl_pack(ctrl_reg), w_data_reg, w_strb_reg)
						& `CTRL1_MASK);
				else if (aw_addr_reg != `OFF_SPARE && aw_addr_reg != `OFF_STATUS)
					bresp <= 2'h2;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= 2'h0;
		end
		else if (ce)
		begin
			if (rvalid && rready)
				rvalid <= 1'b0;
			if (arvalid && !rvalid)
			begin
				rvalid <= 1'b1;
				rresp <= 2'h0;
				if (araddr == `OFF_ENABLE)
					rdata <= {31'h0000_0000, enable_reg};
				else if (araddr == `OFF_SPARE)
					rdata <= 32'h0000_0000;
				else if (araddr == `OFF_CTRL1)
					rdata <= ctrl_pack(ctrl_reg);
				else if (araddr == `OFF_STATUS)
					rdata <= {15'h0000, run, voice_out.data};
				else
				begin
					rdata <= 32'h0000_0000;
					rresp <= 2'h2;
				end
			end
		end
	end

	// core run state
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			state_reg <= voice_pkg::ST_OFF;
		else if (ce)
			case (state_reg)
				voice_pkg::ST_OFF: if (enable_reg) state_reg <= voice_pkg::ST_RUN;
				voice_pkg::ST_RUN: if (!enable_reg) state_reg <= voice_pkg::ST_OFF;
				default: state_reg <= voice_pkg::ST_OFF;
			endcase
	end
	assign run = (state_reg == voice_pkg::ST_RUN);

	// pdm link domain
	logic [1:0] lrst_sync, lce_sync, lside_sync, lack_sync;
	logic left_cap, right_cap, left_q, right_q, lbit;
	logic [1:0] lphase;
	logic [6:0] int1, int2, int3, dly1, dly2, dly3, comb1, comb2, comb3;
	logic [11:0] hold_pcm;
	logic lreq, lrst_n, lce;
	logic [2:0] req_sync;
	logic aack;

	always_ff @(posedge pdm_clk)
	begin
		lrst_sync <= {lrst_sync[0], aresetn};
		lce_sync <= {lce_sync[0], ce};
		lside_sync <= {lside_sync[0], ctrl_reg.channel_side_select};
		lack_sync <= {lack_sync[0], aack};
	end
	assign lrst_n = lrst_sync[1];
	assign lce = lce_sync[1];

	always_ff @(posedge pdm_clk)
		left_cap <= pdm_data;
	always_ff @(negedge pdm_clk)
		right_cap <= pdm_data;
	always_ff @(posedge pdm_clk)
	begin
		left_q <= left_cap;
		right_q <= right_cap;
	end
	assign lbit = lside_sync[1] ? right_q : left_q;

	assign comb1 = int3 - dly1;
	assign comb2 = comb1 - dly2;
	assign comb3 = comb2 - dly3;

	always_ff @(posedge pdm_clk)
	begin
		if (!lrst_n)
		begin
			{int1, int2, int3, dly1, dly2, dly3} <= 42'h0;
			lphase <= 2'h0;
			hold_pcm <= 12'h000;
			lreq <= 1'b0;
		end
		else if (lce)
		begin
			int1 <= int1 + {6'h00, lbit};
			int2 <= int2 + int1;
			int3 <= int3 + int2;
			lphase <= (lphase == 2'(`PDM_DECIM - 1)) ? 2'h0 : lphase + 2'h1;
			if (lphase == 2'(`PDM_DECIM - 1))
			begin
				dly1 <= int3;
				dly2 <= comb1;
				dly3 <= comb2;
				if (lreq == lack_sync[1])
				begin
					hold_pcm <= comb3[6] ? 12'hFFF : {comb3[5:0], 6'h00};
					lreq <= ~lreq;
				end
			end
		end
	end

	AST_LINK_PHASE: assert property (@(posedge pdm_clk) disable iff (!lrst_n)
		(lce && lphase == 2'h3) |=> lphase == 2'h0) else $error("pdm decimation phase did not wrap");

	// crossing of pcm words into aclk domain
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			req_sync <= 3'h0;
			aack <= 1'b0;
		end
		else if (ce)
		begin
			req_sync <= {req_sync[1:0], lreq};
			aack <= req_sync[1];
		end
	end

	// input stage, dc removal
	logic dmic_evt, in_evt, x_valid;
	logic [11:0] raw;
	logic signed [12:0] cen;
	logic signed [15:0] x_q, x_prev, dc_out;
	logic signed [31:0] dc_acc;
	logic signed [33:0] dc_next;
	assign dmic_evt = req_sync[1] ^ req_sync[2];
	assign raw = ctrl_reg.mic ? hold_pcm : adc_data;
	assign in_evt = ctrl_reg.mic ? dmic_evt : adc_valid;
	assign cen = ctrl_reg.polarity ? (`MID_SCALE - {1'b0, raw}) : ({1'b0, raw} - `MID_SCALE);
	assign dc_next = 34'(dc_acc) + (34'(x_q - x_prev) <<< `DC_SHIFT)
		- ((34'(dc_acc) * $signed({32'h0, ctrl_reg.dc_removal_setting})) >>> `DC_SHIFT);
	assign dc_out = (ctrl_reg.dc_removal_setting == 2'h0) ? x_q : sat16(dc_acc >>> `DC_SHIFT);

	always_ff @(posedge aclk)
	begin
		if (!aresetn || (ce && !run))
		begin
			x_valid <= 1'b0;
			x_q <= 16'sh0000;
			x_prev <= 16'sh0000;
			dc_acc <= 32'sh0000_0000;
		end
		else if (ce)
		begin
			x_valid <= in_evt;
			if (in_evt)
			begin
				x_q <= 16'(cen) <<< 3;
				x_prev <= x_q;
			end
			if (x_valid)
				dc_acc <= 32'(sat16(32'(dc_next >>> `DC_SHIFT))) <<< `DC_SHIFT;
		end
	end

	AST_POLARITY: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && run && in_evt) |=> x_q == (16'($past(cen)) <<< 3)) else $error("input offset wrong");
	AST_MIC_ROUTE: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && run && !ctrl_reg.mic && adc_valid) |=> x_valid) else $error("analog sample lost");

	// rate decimation
	logic [5:0] dec_cnt, dec_limit;
	logic signed [21:0] dec_acc;
	logic signed [15:0] avg_q;
	logic avg_valid;
	logic [15:0] recip;
	always_comb
	begin
		dec_limit = 6'h04;
		recip = 16'h3333;
		if (ctrl_reg.encode == voice_pkg::ENC_ALAW || ctrl_reg.encode == voice_pkg::ENC_ULAW)
		begin
			dec_limit = `LOG_DECIM - 6'h01;
			recip = 16'h0666;
		end
		else if (ctrl_reg.encode == voice_pkg::ENC_BYPASS)
			case (ctrl_reg.rate)
				2'h1: begin dec_limit = 6'h09; recip = 16'h199A; end
				2'h2: begin dec_limit = 6'h13; recip = 16'h0CCD; end
				2'h3: begin dec_limit = 6'h27; recip = 16'h0666; end
				default: begin dec_limit = 6'h04; recip = 16'h3333; end
			endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || (ce && !run))
		begin
			dec_cnt <= 6'h00;
			dec_acc <= 22'sh0;
			avg_q <= 16'sh0000;
			avg_valid <= 1'b0;
		end
		else if (ce)
		begin
			avg_valid <= 1'b0;
			if (x_valid)
			begin
				if (dec_cnt >= dec_limit)
				begin
					dec_cnt <= 6'h00;
					dec_acc <= 22'sh0;
					avg_valid <= 1'b1;
					// rounded so that a steady input keeps its value through the mean
					avg_q <= sat16(32'((40'(dec_acc + 22'(dc_out)) * $signed({24'h0, recip})
						+ 40'sh00_0000_8000) >>> 16));
				end
				else
				begin
					dec_cnt <= dec_cnt + 6'h01;
					dec_acc <= dec_acc + 22'(dc_out);
				end
			end
		end
	end

	AST_DECIM_COUNT: assert property (@(posedge aclk) disable iff (!aresetn)
		dec_cnt <= dec_limit || $changed(dec_limit)) else $error("decimation count beyond limit");

	// digital gain in half-decibel steps
	logic [15:0] gain_lut [12];
	assign gain_lut = '{16'h1000, 16'h10F3, 16'h11F4, 16'h1304, 16'h1425, 16'h1557,
		16'h169A, 16'h17F1, 16'h195D, 16'h1ADF, 16'h1C76, 16'h1E26};
	logic [6:0] gcode, gt;
	logic [2:0] gq;
	logic [3:0] gr;
	logic signed [15:0] gain_y;
	assign gcode = (ctrl_reg.gain > `GAIN_MAX) ? `GAIN_MAX : ctrl_reg.gain;
	assign gt = gcode + 7'h08;
	assign gq = 3'(gt / 7'h0C);
	assign gr = 4'(gt % 7'h0C);
	assign gain_y = sat16(32'(((48'(avg_q) * $signed({32'h0, gain_lut[gr]})) <<< gq) >>> 16));

	AST_UNITY_GAIN: assert property (@(posedge aclk) disable iff (!aresetn)
		(ctrl_reg.gain == `GAIN_UNITY) |-> gain_y == avg_q) else $error("code 40 is not unity gain");

	// compression and output
	logic signed [15:0] cv_est;
	logic [15:0] cv_step;
	logic [2:0] cv_hist, cv_cnt;
	logic [7:0] cv_byte;
	logic cv_bit;
	logic [16:0] cv_grow;
	assign cv_bit = (gain_y >= cv_est);
	assign cv_grow = {1'b0, cv_step} + {2'h0, cv_step[15:1]};

	always_ff @(posedge aclk)
	begin
		if (!aresetn || (ce && !run))
		begin
			voice_out <= '0;
			cv_est <= 16'sh0000;
			cv_step <= 16'h0010;
			cv_hist <= 3'h0;
			cv_cnt <= 3'h0;
			cv_byte <= 8'h00;
		end
		else if (ce)
		begin
			voice_out.valid <= 1'b0;
			if (avg_valid)
				case (ctrl_reg.encode)
					voice_pkg::ENC_ALAW, voice_pkg::ENC_ULAW:
					begin
						voice_out.valid <= 1'b1;
						voice_out.data <= {8'h00, (ctrl_reg.encode == voice_pkg::ENC_ALAW
							|| ctrl_reg.companding_law_select) ? alaw_enc(gain_y) : ulaw_enc(gain_y)};
					end
					voice_pkg::ENC_CVSD:
					begin
						cv_hist <= {cv_hist[1:0], cv_bit};
						cv_est <= sat16(32'(cv_est) + (cv_bit ? 32'(cv_step) : -32'(cv_step)));
						if ({cv_hist, cv_bit} == 4'hF || {cv_hist, cv_bit} == 4'h0)
							cv_step <= (cv_grow > 17'h01000) ? 16'h1000 : cv_grow[15:0];
						else if (cv_step > 16'h0010)
							cv_step <= cv_step - {4'h0, cv_step[15:4]};
						cv_byte <= {cv_byte[6:0], cv_bit};
						cv_cnt <= cv_cnt + 3'h1;
						if (cv_cnt == 3'h7)
						begin
							voice_out.valid <= 1'b1;
							voice_out.data <= {8'h00, cv_byte[6:0], cv_bit};
						end
					end
					default:
					begin
						voice_out.valid <= 1'b1;
						voice_out.data <= gain_y;
					end
				endcase
		end
	end

	AST_CVSD_BYTE: assert property (@(posedge aclk) disable iff (!aresetn)
		(voice_out.valid && ctrl_reg.encode == voice_pkg::ENC_CVSD && $stable(ctrl_reg))
		|-> $past(cv_cnt) == 3'h7) else $error("cvsd word emitted before eight bits");
	AST_LOG_SPACING: assert property (@(posedge aclk) disable iff (!aresetn)
		(voice_out.valid && ctrl_reg.encode == voice_pkg::ENC_ULAW) |=> !voice_out.valid[*8])
		else $error("log words too close");
	AST_BYPASS_WORD: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && run && avg_valid && ctrl_reg.encode == voice_pkg::ENC_BYPASS)
		|=> voice_out.valid && voice_out.data == $past(gain_y)) else $error("bypass word wrong");
	AST_RUN_START: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && enable_reg && state_reg == voice_pkg::ST_OFF) |=> run) else $error("core did not start");
	AST_CTRL_RESET: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(aresetn) |-> ctrl_reg.gain == `GAIN_UNITY && ctrl_reg.encode == voice_pkg::ENC_CVSD
		&& ctrl_reg.dc_removal_setting == 2'h1 && !enable_reg) else $error("control reset value wrong");
endmodule

// ### voice_mic_model.sv
// behavioural microphones and sar adc source facing the voice path
`timescale 1ns/1ns
module voice_mic_model (
	input wire logic aclk,
	input wire logic pdm_clk,
	input wire logic left_bit,
	input wire logic right_bit,
	input wire logic adc_go,
	input wire logic [11:0] adc_value,
	output logic pdm_data,
	output logic [11:0] adc_data,
	output logic adc_valid,
	output int adc_sent
);
	logic [1:0] phase = 2'h0;
	initial
	begin
		pdm_data = 1'b0;
		adc_data = 12'h000;
		adc_valid = 1'b0;
		adc_sent = 0;
	end
	// left bit stands across the rising edge, right across the falling edge
	always @(pdm_clk) pdm_data <= pdm_clk ? right_bit : left_bit;
	// one sample every fourth cycle, data churns in between
	always @(posedge aclk)
	begin
		phase <= phase + 2'h1;
		adc_valid <= adc_go && phase == 2'h3;
		adc_data <= (adc_go && phase == 2'h3) ? adc_value : ~adc_data;
		if (adc_go && phase == 2'h3)
			adc_sent <= adc_sent + 1;
	end
endmodule

// ### voice_input_datapath_tb.sv
// self-checking bench for the voice input path
`timescale 1ns/1ns
`define CHECK_EQ(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin miscompares++; $display("[ERR] %s exp %0h got %0h", what, exp, got); end end
module voice_input_datapath_tb;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [3:0] s; logic [1:0] b; logic [1:0] r; logic [31:0] q;} row_t;
	logic aclk = 1'b0, pdm_clk = 1'b0, aresetn = 1'b0, ce = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, pdm_data, adc_valid;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, q;
	logic [11:0] adc_data;
	logic left_bit = 1'b1, right_bit = 1'b0, adc_go = 1'b0;
	logic [11:0] adc_value = 12'h864;
	logic [15:0] v0, last_out = 16'h0000;
	voice_pkg::voice_word_t voice_out;
	int adc_sent, n_checks = 0, miscompares = 0, n_out = 0, e, t;
	row_t rows[6];
	always #4 aclk = ~aclk;
	always #3 pdm_clk = ~pdm_clk;
	voice_input_datapath i_voice_input_datapath (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .pdm_clk(pdm_clk), .pdm_data(pdm_data),
		.adc_data(adc_data), .adc_valid(adc_valid), .voice_out(voice_out));
	voice_mic_model i_voice_mic_model (.aclk(aclk), .pdm_clk(pdm_clk), .left_bit(left_bit), .right_bit(right_bit),
		.adc_go(adc_go), .adc_value(adc_value), .pdm_data(pdm_data), .adc_data(adc_data), .adc_valid(adc_valid),
		.adc_sent(adc_sent));
	always @(posedge aclk)
		if (voice_out.valid === 1'b1)
		begin
			n_out = n_out + 1;
			last_out = voice_out.data;
		end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic hang();
		miscompares++;
		tally_and_finish();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] b);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		b = 2'h1;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int k = 0; k < 100; k++)
		begin
			@(posedge aclk);
			if (aw_ok && w_ok && bvalid === 1'b1)
			begin
				b = bresp;
				bready <= 1'b0;
				return;
			end
			if (!aw_ok && awready === 1'b1)
			begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1)
			begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		hang();
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] b);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int k = 0; k < 100; k++)
		begin
			@(posedge aclk);
			if (rvalid === 1'b1 && arvalid === 1'b0)
			begin
				d = rdata;
				b = rresp;
				rready <= 1'b0;
				return;
			end
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end
		hang();
	endtask
	function automatic logic [31:0] ctl(input logic [6:0] g, input logic [1:0] enc, input logic [1:0] rate,
		input logic law, input logic side, input logic pol, input logic mic);
		return {9'h000, g, 2'h0, enc, 2'h0, rate, 1'b0, law, side, 1'b0, 2'h0, pol, mic};
	endfunction
	task automatic run(input logic [31:0] c, input int n);
		int goal;
		wr(8'h00, 32'h0000_0000, 4'hF, r);
		wr(8'h0C, c, 4'hF, r);
		wr(8'h00, 32'h0000_0001, 4'hF, r);
		n_out = 0;
		goal = adc_sent + n;
		adc_go <= n > 0;
		for (int k = 0; k < 20 * n + 20 && adc_sent < goal; k++)
			@(posedge aclk);
		adc_go <= 1'b0;
		if (adc_sent < goal)
			hang();
		repeat (8) @(posedge aclk);
	endtask
	task automatic wait_words(input int m);
		for (int k = 0; k < 20000 && n_out < m; k++)
			@(posedge aclk);
		if (n_out < m)
			hang();
	endtask
	task automatic reset_and_check();
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h00, q, r);
		`CHECK_EQ("enable rst", 32'h0000_0000, q)
		rd(8'h08, q, r);
		`CHECK_EQ("spare rst", 32'h0000_0000, q)
		rd(8'h0C, q, r);
		`CHECK_EQ("ctrl1 rst", 32'h0028_2004, q)
	endtask
	initial
	begin
		rows = '{'{8'h00, 32'hFFFF_FFFF, 4'hF, 2'h0, 2'h0, 32'h0000_0001}, '{8'h0C, 32'h0050_33EF, 4'hF, 2'h0, 2'h0,
			32'h0050_33EF}, '{8'h0C, 32'h1234_5678, 4'h4, 2'h0, 2'h0, 32'h0034_33EF}, '{8'h08, 32'hFFFF_FFFF, 4'hF,
			2'h0, 2'h0, 32'h0000_0000}, '{8'h20, 32'hFFFF_FFFF, 4'hF, 2'h2, 2'h2, 32'h0000_0000}, '{8'h00,
			32'h0000_0000, 4'hF, 2'h0, 2'h0, 32'h0000_0000}};
		reset_and_check();
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d, rows[i].s, r);
			`CHECK_EQ("bresp", rows[i].b, r)
			rd(rows[i].a, q, r);
			`CHECK_EQ("rresp", rows[i].r, r)
			`CHECK_EQ("rdata", rows[i].q, q)
		end
		for (e = 0; e < 4; e++)
			for (t = 0; t < 4; t++)
			begin
				run(ctl(7'h28, e[1:0], t[1:0], 1'b0, 1'b0, 1'b0, 1'b0), 40);
				`CHECK_EQ("words", (e == 3) ? (8 >> t) : 1, n_out)
			end
		rd(8'h1C, q, r);
		`CHECK_EQ("status", {16'h0001, last_out}, q)
		run(ctl(7'h28, 2'h3, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0), 5);
		v0 = last_out;
		`CHECK_EQ("pos", 1'b1, $signed(v0) > 0)
		run(ctl(7'h28, 2'h3, 2'h0, 1'b0, 1'b0, 1'b1, 1'b0), 5);
		`CHECK_EQ("neg", 16'h0000 - v0, last_out)
		run(ctl(7'h50, 2'h3, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0), 5);
		`CHECK_EQ("gain up", 1'b1, $signed(last_out) > $signed(v0))
		run(ctl(7'h00, 2'h3, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0), 5);
		`CHECK_EQ("gain dn", 1'b1, $signed(last_out) < $signed(v0))
		run(ctl(7'h28, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0), 40);
		v0 = last_out;
		`CHECK_EQ("a-law code", 16'h00FC, v0)
		run(ctl(7'h28, 2'h1, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0), 40);
		`CHECK_EQ("a-law", v0, last_out)
		`CHECK_EQ("a-law words", 1, n_out)
		run(ctl(7'h28, 2'h1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0), 40);
		`CHECK_EQ("u-law", 1'b1, last_out !== v0)
		`CHECK_EQ("u-law code", 16'h00D2, last_out)
		run(ctl(7'h28, 2'h3, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1), 0);
		wait_words(10);
		`CHECK_EQ("left", 1'b1, $signed(last_out) > 0)
		run(ctl(7'h28, 2'h3, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1), 0);
		wait_words(10);
		`CHECK_EQ("right", 1'b1, $signed(last_out) < 0)
		reset_and_check();
		tally_and_finish();
	end
endmodule
